// *** src/pll_regs_consts.svh ***
// Purpose: Addresses, field positions, reset values and timing figures of the
//          detector and exact frequency registers.
// Assumes: Included by bare name wherever the constants are needed.
// Notes:   Definitions only.
`ifndef PLL_REGS_CONSTS_SVH
`define PLL_REGS_CONSTS_SVH

`define REG_ADDR_W        5
`define REG_DATA_W        24
`define DETECTOR_ADDR     5'h0B
`define EXACT_ADDR        5'h0C

`define DETECTOR_RESET    24'h0F8061
`define EXACT_RESET       14'h0000

`define DELAY_MSB         2
`define DELAY_LSB         0
`define UP_EN_BIT         5
`define DOWN_EN_BIT       6
`define SLIP_MSB          8
`define SLIP_LSB          7
`define FORCE_UP_BIT      9
`define FORCE_DOWN_BIT    10
`define RSV_MSB           21
`define RSV_LSB           11
`define RSV_RESET         11'h1F0
`define LEVEL_BIT         22

`define EXACT_MSB         13
`define EXACT_W           14
`define EXACT_MIN_COUNT   14'h0002

`define SLIP_OFF          2'h0
`define SLIP_SMALL        2'h1
`define SLIP_MID          2'h2
`define SLIP_LARGE        2'h3
`define SLIP_TH_W         16
`define SLIP_TH_OFF_PS    16'h0000
`define SLIP_TH_SMALL_PS  16'h1518
`define SLIP_TH_MID_PS    16'h3840
`define SLIP_TH_LARGE_PS  16'h5E24

`endif

// *** src/pll_regs_pkg.sv ***
// Purpose: Types shared by the detector / exact frequency register bank.
// Assumes: pll_regs_consts.svh supplies widths.
// Notes:   Whole module state is one packed struct.
`include "pll_regs_consts.svh"

package pll_regs_pkg;

	typedef struct packed {
		logic [`REG_DATA_W-1:0] detector_cfg;
		logic [`EXACT_W-1:0]    exact_cfg;
		logic                   up_s1;
		logic                   up_s2;
		logic                   down_s1;
		logic                   down_s2;
		logic                   charge_pump_up;
		logic                   charge_pump_down;
		logic [`SLIP_TH_W-1:0]  slip_threshold_ps;
		logic                   exact_enable;
		logic [`REG_DATA_W-1:0] rdata;
		logic                   rvalid;
		logic                   written;
	} state_t;

endpackage

// *** src/pll_detector_exact_freq_regs.sv ***
// Purpose: Detector configuration and exact frequency count registers,
//          with the detector output gating and test overrides they steer.
// Assumes: Register strobes come from the serial port engine on clk_sys;
//          detector pulses arrive from outside and are synchronised here.
// Notes:   Reads answer one cycle after the strobe; writes land at once.
//          Charge pump outputs lag the detector pins by three clocks.
//          Exact enable trails the stored count by one clock.
//
// Notes on behaviour
// RULE1: Bits 2:0 of the detector register hold a read/write reset-path delay select, default 1.
// RULE2: The detector up output passes only while bit 5 is 1, read/write, default 1.
// RULE3: The detector down output passes only while bit 6 is 1, read/write, default 1.
// RULE4: Bits 8:7 select the slip threshold: off, 5.4 ns, 14.4 ns or 24.1 ns.
// RULE5: Bit 9 set forces the charge pump up output on, default 0, test only.
// RULE6: Bit 10 set forces the charge pump down output on, default 0, test only.
// RULE7: Bit 22 picks the serial-out pin level, 0 for 1.8 V and 1 for 3.3 V, default 0.
// RULE8: Reset loads the detector register at 0x0B with 0x0F8061, reserved 21:11 being 0x1F0.
// RULE9: Bits 13:0 of the exact register hold a channel count; 0 and 1 disable, 2 up enable.
// RULE10: The host picks a count that makes comparison rate over correction rate an integer.
// RULE11: Reset clears the exact register at 0x0C to zero, leaving the mode off.
// RULE12: The host writes reserved fields back at their defaults and relies on none of them; the bench writes ones into exact bits 23:14.
`timescale 1ns/1ps
`include "pll_regs_consts.svh"

module pll_detector_exact_freq_regs (
	input  wire logic                    clk_sys,                     // System clock, 250 MHz
	input  wire logic                    rstn,                        // Async reset, active low
	input  wire logic                    wr_en,                       // Register write strobe
	input  wire logic                    rd_en,                       // Register read strobe
	input  wire logic [`REG_ADDR_W-1:0]  addr,                        // Register address
	input  wire logic [`REG_DATA_W-1:0]  wdata,                       // Write data
	output logic      [`REG_DATA_W-1:0]  rdata,                       // Read data
	output logic                         rvalid,                      // Read data valid pulse
	input  wire logic                    detector_up_in,              // Raw detector up pulse
	input  wire logic                    detector_down_in,            // Raw detector down pulse
	output logic      [2:0]              reset_path_delay_select,     // Reset path delay
	output logic                         detector_up_output_enable,   // Up output enable
	output logic                         detector_down_output_enable, // Down output enable
	output logic      [1:0]              slip_prevention_mode,        // Slip mode field
	output logic      [`SLIP_TH_W-1:0]   slip_threshold_ps,           // Slip threshold, ps
	output logic                         charge_pump_up,              // Charge pump up drive
	output logic                         charge_pump_down,            // Charge pump down drive
	output logic                         lock_serial_out_3v3,         // Serial-out pin level
	output logic      [`EXACT_W-1:0]     exact_channel_count,         // Exact mode count
	output logic                         exact_enable                 // Exact mode active
);

	pll_regs_pkg::state_t st_r;
	pll_regs_pkg::state_t st_nxt;

	// Threshold in picoseconds for each slip mode
	function automatic logic [`SLIP_TH_W-1:0] slip_threshold(input logic [1:0] mode);
		case (mode)
			`SLIP_OFF:   slip_threshold = `SLIP_TH_OFF_PS;
			`SLIP_SMALL: slip_threshold = `SLIP_TH_SMALL_PS;
			`SLIP_MID:   slip_threshold = `SLIP_TH_MID_PS;
			`SLIP_LARGE: slip_threshold = `SLIP_TH_LARGE_PS;
			default:     slip_threshold = `SLIP_TH_OFF_PS;
		endcase
	endfunction

	always_comb begin
		st_nxt = st_r;
		// Detector pulses are asynchronous to clk_sys
		st_nxt.up_s1   = detector_up_in;
		st_nxt.up_s2   = st_r.up_s1;
		st_nxt.down_s1 = detector_down_in;
		st_nxt.down_s2 = st_r.down_s1;

		// Whole word stored, reserved bits included, so readback is exact
		if (wr_en && addr == `DETECTOR_ADDR) begin
			st_nxt.detector_cfg = wdata;                                  // RULE1
			st_nxt.written      = 1'b1;
		end
		// Bits above the count are not stored and read back as zero
		if (wr_en && addr == `EXACT_ADDR) begin
			st_nxt.exact_cfg = wdata[`EXACT_MSB:0];                       // RULE9
			st_nxt.written   = 1'b1;
		end

		// Force wins over enable so a test can run the pump alone
		st_nxt.charge_pump_up = (st_r.up_s2 & st_r.detector_cfg[`UP_EN_BIT])   // RULE2
			| st_r.detector_cfg[`FORCE_UP_BIT];                               // RULE5
		st_nxt.charge_pump_down = (st_r.down_s2 & st_r.detector_cfg[`DOWN_EN_BIT]) // RULE3
			| st_r.detector_cfg[`FORCE_DOWN_BIT];                             // RULE6
		// Registered decode, one cycle behind the mode field
		st_nxt.slip_threshold_ps =
			slip_threshold(st_r.detector_cfg[`SLIP_MSB:`SLIP_LSB]);            // RULE4
		st_nxt.exact_enable = (st_r.exact_cfg >= `EXACT_MIN_COUNT);         // RULE9

		// Read sees the value before a same-cycle write
		st_nxt.rvalid = rd_en;
		st_nxt.rdata  = '0;
		if (rd_en) begin
			case (addr)
				`DETECTOR_ADDR: st_nxt.rdata = st_r.detector_cfg;
				`EXACT_ADDR:    st_nxt.rdata = {{(`REG_DATA_W-`EXACT_W){1'b0}}, st_r.exact_cfg};
				default:        st_nxt.rdata = '0;
			endcase
		end
	end

	// Reset values are constants only; reserved field included
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_r <= '{detector_cfg: `DETECTOR_RESET,                       // RULE8
				exact_cfg: `EXACT_RESET,                                    // RULE11
				default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata                       = st_r.rdata;
	assign rvalid                      = st_r.rvalid;
	assign reset_path_delay_select     = st_r.detector_cfg[`DELAY_MSB:`DELAY_LSB];
	assign detector_up_output_enable   = st_r.detector_cfg[`UP_EN_BIT];
	assign detector_down_output_enable = st_r.detector_cfg[`DOWN_EN_BIT];
	assign slip_prevention_mode        = st_r.detector_cfg[`SLIP_MSB:`SLIP_LSB];
	assign slip_threshold_ps           = st_r.slip_threshold_ps;
	assign charge_pump_up              = st_r.charge_pump_up;
	assign charge_pump_down            = st_r.charge_pump_down;
	assign lock_serial_out_3v3         = st_r.detector_cfg[`LEVEL_BIT];   // RULE7
	assign exact_channel_count         = st_r.exact_cfg;
	assign exact_enable                = st_r.exact_enable;

	// All checks sample on clk_sys and sleep while reset is low
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	// Until the first write both registers show their defaults
	detector_default_a: assert property (!st_r.written |-> // RULE8
		(st_r.detector_cfg == `DETECTOR_RESET
		&& st_r.detector_cfg[`RSV_MSB:`RSV_LSB] == `RSV_RESET
		&& reset_path_delay_select == 3'h1
		&& detector_up_output_enable && detector_down_output_enable))
		else $error("detector register lost its default before any write");

	exact_default_a: assert property (!st_r.written |-> // RULE11
		(exact_channel_count == `EXACT_RESET && !exact_enable))
		else $error("exact register not cleared before any write");

	delay_readback_a: assert property ( // RULE1
		(wr_en && addr == `DETECTOR_ADDR) ##1 !wr_en
		##1 (rd_en && addr == `DETECTOR_ADDR && !wr_en)
		|=> (rvalid && rdata[`DELAY_MSB:`DELAY_LSB] == $past(wdata[`DELAY_MSB:`DELAY_LSB], 3)))
		else $error("delay select did not read back as written");

	up_gated_a: assert property ( // RULE2
		(!st_r.detector_cfg[`UP_EN_BIT] && !st_r.detector_cfg[`FORCE_UP_BIT])
		|=> !charge_pump_up)
		else $error("up output passed while disabled");

	down_gated_a: assert property ( // RULE3
		(!st_r.detector_cfg[`DOWN_EN_BIT] && !st_r.detector_cfg[`FORCE_DOWN_BIT])
		|=> !charge_pump_down)
		else $error("down output passed while disabled");

	slip_mid_a: assert property ( // RULE4
		(slip_prevention_mode == `SLIP_MID) [*2] |-> slip_threshold_ps == `SLIP_TH_MID_PS)
		else $error("slip threshold wrong for middle mode");

	slip_off_a: assert property ( // RULE4
		(slip_prevention_mode == `SLIP_OFF) ##1 (slip_prevention_mode == `SLIP_OFF)
		|-> slip_threshold_ps == 16'h0000)
		else $error("slip threshold not zero when disabled");

	force_up_a: assert property ( // RULE5
		st_r.detector_cfg[`FORCE_UP_BIT] |=> charge_pump_up)
		else $error("forced up output not on");

	force_down_a: assert property ( // RULE6
		st_r.detector_cfg[`FORCE_DOWN_BIT] |=> charge_pump_down)
		else $error("forced down output not on");

	level_write_a: assert property ( // RULE7
		(wr_en && addr == `DETECTOR_ADDR)
		|=> lock_serial_out_3v3 == $past(wdata[`LEVEL_BIT]))
		else $error("pin level did not follow the write");

	exact_enable_a: assert property ( // RULE9
		(wr_en && addr == `EXACT_ADDR)
		|-> ##2 (exact_enable == ($past(wdata[`EXACT_MSB:0], 2) >= `EXACT_MIN_COUNT)))
		else $error("exact enable wrong for written count");

	unmapped_read_a: assert property (
		(rd_en && addr != `DETECTOR_ADDR && addr != `EXACT_ADDR) |=> (rvalid && rdata == '0))
		else $error("unmapped read did not return zero");

	// Read port: one-cycle answer, idle data held at zero
	read_pulse_a: assert property (
		rd_en |=> rvalid)
		else $error("read strobe got no valid pulse");

	read_idle_a: assert property (
		!rd_en |=> (!rvalid && rdata == '0))
		else $error("read data not idle after a quiet cycle");

	// Without a same-cycle write the readback matches the live fields
	detector_fields_a: assert property ( // RULE1
		(rd_en && addr == `DETECTOR_ADDR && !wr_en) |=> (rvalid
		&& rdata[`DELAY_MSB:`DELAY_LSB] == reset_path_delay_select
		&& rdata[`UP_EN_BIT] == detector_up_output_enable
		&& rdata[`DOWN_EN_BIT] == detector_down_output_enable
		&& rdata[`SLIP_MSB:`SLIP_LSB] == slip_prevention_mode
		&& rdata[`LEVEL_BIT] == lock_serial_out_3v3))
		else $error("detector readback differs from its field outputs");

	exact_read_a: assert property ( // RULE9
		(rd_en && addr == `EXACT_ADDR && !wr_en) |=> (rvalid
		&& rdata[`REG_DATA_W-1:`EXACT_W] == '0
		&& rdata[`EXACT_MSB:0] == exact_channel_count))
		else $error("exact readback differs from the stored count");

	// Field outputs move only on a write to their own register
	detector_hold_a: assert property ( // RULE7
		!(wr_en && addr == `DETECTOR_ADDR) |=> $stable({reset_path_delay_select,
		detector_up_output_enable, detector_down_output_enable,
		slip_prevention_mode, lock_serial_out_3v3}))
		else $error("detector fields changed without a write");

	exact_hold_a: assert property ( // RULE9
		!(wr_en && addr == `EXACT_ADDR) |=> $stable(exact_channel_count))
		else $error("exact count changed without a write");

	exact_write_a: assert property ( // RULE9
		(wr_en && addr == `EXACT_ADDR)
		|=> exact_channel_count == $past(wdata[`EXACT_MSB:0]))
		else $error("exact count did not take the written value");

	delay_write_a: assert property ( // RULE1
		(wr_en && addr == `DETECTOR_ADDR)
		|=> reset_path_delay_select == $past(wdata[`DELAY_MSB:`DELAY_LSB]))
		else $error("delay select did not take the written value");

	up_enable_write_a: assert property ( // RULE2
		(wr_en && addr == `DETECTOR_ADDR)
		|=> detector_up_output_enable == $past(wdata[`UP_EN_BIT]))
		else $error("up enable did not take the written value");

	down_enable_write_a: assert property ( // RULE3
		(wr_en && addr == `DETECTOR_ADDR)
		|=> detector_down_output_enable == $past(wdata[`DOWN_EN_BIT]))
		else $error("down enable did not take the written value");

	slip_write_a: assert property ( // RULE4
		(wr_en && addr == `DETECTOR_ADDR)
		|=> slip_prevention_mode == $past(wdata[`SLIP_MSB:`SLIP_LSB]))
		else $error("slip mode did not take the written value");

	// Reserved bits are kept so a host can read back what it wrote
	reserved_write_a: assert property ( // RULE8
		(wr_en && addr == `DETECTOR_ADDR)
		|=> st_r.detector_cfg[`RSV_MSB:`RSV_LSB] == $past(wdata[`RSV_MSB:`RSV_LSB]))
		else $error("reserved bits did not take the written value");

	// Detector path: two sync stages then the output flop
	up_sync_a: assert property ( // RULE2
		(detector_up_in && detector_up_output_enable) [*3] |=> charge_pump_up)
		else $error("enabled up pulse did not reach the charge pump");

	down_sync_a: assert property ( // RULE3
		(detector_down_in && detector_down_output_enable) [*3] |=> charge_pump_down)
		else $error("enabled down pulse did not reach the charge pump");

	up_quiet_a: assert property ( // RULE5
		(!detector_up_in && !st_r.detector_cfg[`FORCE_UP_BIT]) [*3] |=> !charge_pump_up)
		else $error("up output on with no pulse and no force");

	down_quiet_a: assert property ( // RULE6
		(!detector_down_in && !st_r.detector_cfg[`FORCE_DOWN_BIT]) [*3] |=> !charge_pump_down)
		else $error("down output on with no pulse and no force");

	// An enabled, synchronised pulse always reaches the output
	up_follow_a: assert property ( // RULE2
		(st_r.up_s2 && detector_up_output_enable) |=> charge_pump_up)
		else $error("synchronised up pulse was blocked");

	down_follow_a: assert property ( // RULE3
		(st_r.down_s2 && detector_down_output_enable) |=> charge_pump_down)
		else $error("synchronised down pulse was blocked");

	slip_small_a: assert property ( // RULE4
		(slip_prevention_mode == `SLIP_SMALL) [*2] |-> slip_threshold_ps == `SLIP_TH_SMALL_PS)
		else $error("slip threshold wrong for small mode");

	slip_large_a: assert property ( // RULE4
		(slip_prevention_mode == `SLIP_LARGE) [*2] |-> slip_threshold_ps == `SLIP_TH_LARGE_PS)
		else $error("slip threshold wrong for large mode");

	// Enable trails the count by one cycle, hence two stable samples
	exact_off_a: assert property ( // RULE9
		(exact_channel_count < `EXACT_MIN_COUNT) [*2] |-> !exact_enable)
		else $error("exact mode on with a count below two");

	exact_on_a: assert property ( // RULE9
		(exact_channel_count >= `EXACT_MIN_COUNT) [*2] |-> exact_enable)
		else $error("exact mode off with a count of two or more");

	detector_write_c: cover property (wr_en && addr == `DETECTOR_ADDR);
	exact_on_c:       cover property (!exact_enable ##1 exact_enable);
	force_up_c:       cover property (st_r.detector_cfg[`FORCE_UP_BIT] ##1 charge_pump_up);
	readback_c:       cover property (rd_en && addr == `EXACT_ADDR ##1 rvalid);
	write_read_c:     cover property (wr_en ##2 rd_en ##1 rvalid);

endmodule

// *** test/spi_host_model.sv ***
// Purpose: Register-port host standing in for the serial port engine.
// Assumes: Requests launch 1 ns after a rising clk_sys edge.
// Notes:   Released address and data lines show the inverse of the last value.
`timescale 1ns/1ps
`include "pll_regs_consts.svh"
module spi_host_model (
	input  wire logic                   clk_sys, // System clock
	output logic                        wr_en,   // Write strobe
	output logic                        rd_en,   // Read strobe
	output logic      [`REG_ADDR_W-1:0] addr,    // Register address
	output logic      [`REG_DATA_W-1:0] wdata,   // Write data
	input  wire logic [`REG_DATA_W-1:0] rdata,   // Read data
	input  wire logic                   rvalid   // Read data valid
);
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr  = 5'h00;
		wdata = 24'h000000;
	end
	task automatic write(input logic [`REG_ADDR_W-1:0] a, input logic [`REG_DATA_W-1:0] d);
		@(posedge clk_sys);
		#1;
		wr_en = 1'b1;
		addr  = a;
		wdata = (a == `DETECTOR_ADDR) ? {1'b0, d[22], `RSV_RESET, d[10:5], 2'h0, d[2:0]} : d;
		@(posedge clk_sys);
		#1;
		wr_en = 1'b0;
		addr  = ~addr;
		wdata = ~wdata;
	endtask
	// Data is taken one cycle after the strobe edge, while rvalid stands
	task automatic read(input logic [`REG_ADDR_W-1:0] a, output logic v,
		output logic [`REG_DATA_W-1:0] q);
		@(posedge clk_sys);
		#1;
		rd_en = 1'b1;
		addr  = a;
		@(posedge clk_sys);
		#1;
		rd_en = 1'b0;
		addr  = ~addr;
		v     = rvalid;
		q     = rdata;
	endtask
endmodule

// *** test/tb_top.sv ***
// Purpose: Self-checking bench for the detector and exact frequency registers.
// Assumes: Host model drives the register port; bench drives detector pulses.
// Notes:   Bench model keeps both registers and checks every output.
`timescale 1ns/1ps
`include "pll_regs_consts.svh"
module tb_top;
	logic                   clk_sys, rstn, wr_en, rd_en, rvalid, up_in, down_in, rv;
	logic                   up_oe, down_oe, cp_up, cp_down, lvl_3v3, ex_on;
	logic [`REG_ADDR_W-1:0] addr;
	logic [`REG_DATA_W-1:0] wdata, rdata, got, d, det;
	logic [2:0]             delay_sel;
	logic [1:0]             slip_mode;
	logic [`SLIP_TH_W-1:0]  slip_th;
	logic [`EXACT_W-1:0]    ex_cnt;
	int                     miscompares = 0, tests_run = 0, seed = 32'h76f8, ex;
	int                     th_ps[4] = '{0, 5400, 14400, 24100};
	int                     cnt_tab[6] = '{0, 1, 2, 3, 16383, 0};
	pll_detector_exact_freq_regs dut (.clk_sys(clk_sys), .rstn(rstn), .wr_en(wr_en),
		.rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid),
		.detector_up_in(up_in), .detector_down_in(down_in), .reset_path_delay_select(delay_sel),
		.detector_up_output_enable(up_oe), .detector_down_output_enable(down_oe),
		.slip_prevention_mode(slip_mode), .slip_threshold_ps(slip_th), .charge_pump_up(cp_up),
		.charge_pump_down(cp_down), .lock_serial_out_3v3(lvl_3v3),
		.exact_channel_count(ex_cnt), .exact_enable(ex_on));
	spi_host_model host (.clk_sys(clk_sys), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wdata(wdata), .rdata(rdata), .rvalid(rvalid));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic test_done;
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rdchk(input logic [`REG_ADDR_W-1:0] a, input logic [23:0] e);
		host.read(a, rv, got);
		chk({23'h0, rv}, 24'h1);
		chk(got, e);
	endtask
	task automatic chk_fields;
		chk(delay_sel, det[2:0]);
		chk(up_oe, det[5]);
		chk(down_oe, det[6]);
		chk(slip_mode, det[8:7]);
		chk(slip_th, 24'(th_ps[det[8:7]]));
		chk(cp_up, (up_in & det[5]) | det[9]);
		chk(cp_down, (down_in & det[6]) | det[10]);
		chk(lvl_3v3, det[22]);
		chk(ex_cnt, 24'(ex));
		chk(ex_on, ex >= 2);
		rdchk(`DETECTOR_ADDR, det);
		rdchk(`EXACT_ADDR, 24'(ex));
	endtask
	task automatic do_reset;
		rstn = 1'b0;
		det  = `DETECTOR_RESET;
		ex   = 0;
		repeat (3) @(posedge clk_sys);
		#1;
		rstn = 1'b1;
	endtask
	// Whole run is a few hundred cycles; this only cuts a hang short
	initial begin
		repeat (3000) @(posedge clk_sys);
		miscompares++;
		test_done;
	end
	initial begin
		up_in   = 1'b0;
		down_in = 1'b0;
		do_reset;
		chk_fields;
		rdchk(5'h0A, 24'h0);
		for (int i = 0; i < 24; i++) begin
			d = 24'($random(seed));
			host.write(`DETECTOR_ADDR, d);
			det     = {1'b0, d[22], `RSV_RESET, d[10:5], 2'h0, d[2:0]};
			up_in   = d[23];
			down_in = d[3];
			rdchk(`DETECTOR_ADDR, det);
			repeat (4) @(posedge clk_sys);
			#1;
			chk_fields;
		end
		cnt_tab[5] = $random(seed) & 32'h3FFF;
		foreach (cnt_tab[k]) begin
			ex = cnt_tab[k];
			host.write(`EXACT_ADDR, 24'(ex) | 24'hFFC000);
			repeat (2) @(posedge clk_sys);
			#1;
			chk_fields;
		end
		up_in   = 1'b0;
		down_in = 1'b0;
		do_reset;
		chk_fields;
		test_done;
	end
endmodule
